// File: hdl/cxm_pkg.sv
// shared constants and types for the transceiver mode and supply monitor
package cxm_pkg;
    localparam int          CLK_PERIOD_NS   = 40;
    // register map, byte offsets, 8-bit data
    localparam logic [7:0]  ADDR_MODE_CTRL  = 8'h00;
    localparam logic [7:0]  ADDR_INT_CTRL   = 8'h01;
    localparam logic [7:0]  ADDR_INT_STATUS = 8'h02;
    localparam logic [7:0]  ADDR_WD_STATUS  = 8'h03;
    // mode control fields
    localparam int          MODE_LSB        = 0;
    localparam int          PSPLIT_BIT      = 2;
    // int control fields
    localparam int          CAN_STBY_BIT    = 0;
    localparam int          RTH_BIT         = 1;
    // int status fields
    localparam int          IRQ_MAIN_BIT    = 0;
    localparam int          IRQ_XCVR_BIT    = 1;
    localparam int          IRQ_WAKE_BIT    = 2;
    // watchdog and status fields
    localparam int          MAIN_OK_BIT     = 0;
    localparam int          XCVR_OK_BIT     = 1;
    // reset values
    localparam logic [1:0]  MODE_RST        = 2'h0;
    localparam logic        PSPLIT_RST      = 1'h0;
    localparam logic        CAN_STBY_RST    = 1'h0;
    localparam logic        RTH_RST         = 1'h0;
    // operating mode codes
    localparam logic [1:0]  MODE_STANDBY    = 2'h0;
    localparam logic [1:0]  MODE_SLEEP      = 2'h1;
    localparam logic [1:0]  MODE_NORMAL_EXT = 2'h2;
    localparam logic [1:0]  MODE_NORMAL     = 2'h3;
    // external transistor activation currents
    localparam int          PSPLIT_LO_MA    = 85;
    localparam int          PSPLIT_HI_MA    = 50;
    // timing, least times round up, longest times round down
    localparam int          WAKE_MIN_NS     = 5000;
    localparam int          WAKE_MIN_CYC    = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WAKE_TO_US      = 1000;
    localparam int          WAKE_TO_CYC     = (WAKE_TO_US * 1000) / CLK_PERIOD_NS;
    localparam int          TXD_TO_US       = 1000;
    localparam int          TXD_TO_CYC      = (TXD_TO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RST_PULSE_US    = 1000;
    localparam int          RST_PULSE_CYC   = (RST_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 16;

    typedef enum logic [3:0] {
        WK_REC1 = 4'b0001,
        WK_DOM1 = 4'b0010,
        WK_REC2 = 4'b0100,
        WK_DOM2 = 4'b1000
    } cxm_wake_e;
endpackage : cxm_pkg

// File: hdl/cxm_wake_if.sv
// carrier between the top level and the bus wake-up filter
interface cxm_wake_if;
    logic enable;
    logic bus_dom;
    logic wake;
    modport ctrl (output enable, output bus_dom, input wake);
    modport filt (input enable, input bus_dom, output wake);
endinterface : cxm_wake_if

// File: hdl/cxm_wake_filter.sv
// bus wake-up pattern filter: recessive, dominant, recessive, dominant
module cxm_wake_filter #(
    parameter logic [15:0] TIMEOUT_CYC = 16'(cxm_pkg::WAKE_TO_CYC)
) (
    input  wire logic clk,
    input  wire logic rst_n,
    cxm_wake_if.filt  wk
);
    localparam logic [15:0] MIN_CYC = 16'(cxm_pkg::WAKE_MIN_CYC);

    cxm_pkg::cxm_wake_e state_ff;
    logic [15:0]        run_ff;
    logic [15:0]        to_ff;
    logic               last_ff;
    logic               wake_ff;
    logic               want_dom;
    logic               phase_ok;
    logic               timed_out;

    assign want_dom  = (state_ff == cxm_pkg::WK_DOM1) || (state_ff == cxm_pkg::WK_DOM2);
    // a phase counts once its level has lasted its minimum
    assign phase_ok  = (wk.bus_dom == want_dom) && (last_ff == want_dom) && (run_ff >= MIN_CYC);
    assign timed_out = (state_ff != cxm_pkg::WK_REC1) && (to_ff >= TIMEOUT_CYC);
    assign wk.wake   = wake_ff;

    // length of the current unbroken bus level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff  <= 16'h0000;
            last_ff <= 1'b0;
        end else begin
            last_ff <= wk.bus_dom;
            if (!wk.enable || wk.bus_dom != last_ff || phase_ok)
                run_ff <= 16'h0001;
            else if (run_ff != 16'hffff)
                run_ff <= run_ff + 16'h0001;
        end
    end

    // short glitches between phases are simply ignored, the phase waits on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= cxm_pkg::WK_REC1;
            wake_ff  <= 1'b0;
        end else begin
            wake_ff <= 1'b0;
            if (!wk.enable || timed_out) begin
                state_ff <= cxm_pkg::WK_REC1;
            end else if (phase_ok) begin
                unique case (state_ff)
                    cxm_pkg::WK_REC1: state_ff <= cxm_pkg::WK_DOM1;
                    cxm_pkg::WK_DOM1: state_ff <= cxm_pkg::WK_REC2;
                    cxm_pkg::WK_REC2: state_ff <= cxm_pkg::WK_DOM2;
                    cxm_pkg::WK_DOM2: begin
                        state_ff <= cxm_pkg::WK_REC1;
                        wake_ff  <= 1'b1;
                    end
                endcase
            end
        end
    end

    // whole pattern must finish inside the timeout window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            to_ff <= 16'h0000;
        else if (state_ff == cxm_pkg::WK_REC1 || !wk.enable)
            to_ff <= 16'h0000;
        else if (to_ff != 16'hffff)
            to_ff <= to_ff + 16'h0001;
    end
endmodule : cxm_wake_filter

// File: hdl/cxm_can_xcvr_mode_supply_monitor.sv
// can transceiver mode control, supply monitoring and register port
//
// Design decisions made here: strobed register access and the register addresses.

// Notes on behaviour
// - split bit picks 85 or 50 mA
// - main regulator undervoltage triggers system reset
// - threshold bit picks 90 or 70 percent
// - main warning interrupt at 90 percent
// - main regulator health readable as status
// - mode code switches transceiver regulator; on only at 11
// - transceiver regulator warning below 90 percent
// - transceiver ok bit real only in normal
// - active needs normal, no standby, supply ok
// - active passes receive data and transmit data
// - standby bit gives lowpower with bus wake
// - standby or sleep without standby bit: off
// - wake needs four timed phases within timeout
// - split output enabled only in active
// - long dominant transmit disables transmitter
// - undriven transmit input reads recessive high
// - write one clears pending interrupt bit
// - interrupt output low while any flag pending
// - internal reset drives pulse on reset line
module cxm_can_xcvr_mode_supply_monitor #(
    parameter logic [15:0] WAKE_TO_CYC   = 16'(cxm_pkg::WAKE_TO_CYC),
    parameter logic [15:0] TXD_TO_CYC    = 16'(cxm_pkg::TXD_TO_CYC),
    parameter logic [15:0] RST_PULSE_CYC = 16'(cxm_pkg::RST_PULSE_CYC)
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       main_above_90,
    input  wire logic       main_above_70,
    input  wire logic       xcvr_above_90,
    input  wire logic       xcvr_pin_ok,
    output logic            xcvr_regulator_en,
    output logic            pnp_drive_at_50ma,
    input  wire logic       can_transmit_data,
    input  wire logic       can_transmit_data_oe,
    output logic            can_receive_data,
    input  wire logic       bus_rx_dominant,
    output logic            bus_tx_dominant,
    output logic            xcvr_active,
    output logic            xcvr_lowpower,
    output logic            split_en,
    output logic            interrupt_out_n_o,
    output logic            interrupt_out_n_oe_n,
    output logic            system_reset_line_n_o,
    output logic            system_reset_line_n_oe_n
);
    logic [1:0]  operating_mode_field_ff;
    logic        power_split_select_ff;
    logic        can_standby_select_ff;
    logic        reset_threshold_select_ff;
    logic [2:0]  int_status_ff;
    logic [2:0]  nxt_int_status;
    logic [7:0]  reg_rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        main_warn_ff;
    logic        xcvr_warn_ff;
    logic        main_uv;
    logic        normal_mode;
    logic        active;
    logic        lowpower;
    logic        txd_eff;
    logic        txd_last_ff;
    logic        tx_blocked_ff;
    logic [15:0] txd_cnt_ff;
    logic [15:0] rst_cnt_ff;
    logic        rxd_ff;
    logic        main_supply_ok_flag;
    logic        xcvr_supply_ok_flag;
    logic        wr_mode;
    logic        wr_ictl;
    logic        wr_stat;

    cxm_wake_if wk_bus ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    assign wr_mode = reg_wr && hit(reg_addr, cxm_pkg::ADDR_MODE_CTRL);
    assign wr_ictl = reg_wr && hit(reg_addr, cxm_pkg::ADDR_INT_CTRL);
    assign wr_stat = reg_wr && hit(reg_addr, cxm_pkg::ADDR_INT_STATUS);

    // control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            operating_mode_field_ff   <= cxm_pkg::MODE_RST;
            power_split_select_ff     <= cxm_pkg::PSPLIT_RST;
            can_standby_select_ff     <= cxm_pkg::CAN_STBY_RST;
            reset_threshold_select_ff <= cxm_pkg::RTH_RST;
        end else begin
            if (wr_mode) begin
                operating_mode_field_ff <= reg_wdata[cxm_pkg::MODE_LSB +: 2];
                power_split_select_ff   <= reg_wdata[cxm_pkg::PSPLIT_BIT];
            end
            if (wr_ictl) begin
                can_standby_select_ff     <= reg_wdata[cxm_pkg::CAN_STBY_BIT];
                reset_threshold_select_ff <= reg_wdata[cxm_pkg::RTH_BIT];
            end
        end
    end

    // 0 keeps the 85 mA point, 1 moves it to 50 mA
    assign pnp_drive_at_50ma = power_split_select_ff;

    // supply monitoring
    assign main_uv = reset_threshold_select_ff ? !main_above_70 : !main_above_90;
    assign main_supply_ok_flag = !main_uv;
    assign normal_mode = operating_mode_field_ff[1];
    assign xcvr_regulator_en = (operating_mode_field_ff == cxm_pkg::MODE_NORMAL);
    // outside normal the regulator may be off, so its comparator means nothing
    assign xcvr_supply_ok_flag = normal_mode ? xcvr_above_90 : 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_warn_ff <= 1'b0;
            xcvr_warn_ff <= 1'b0;
        end else begin
            main_warn_ff <= !main_above_90;
            xcvr_warn_ff <= xcvr_regulator_en && !xcvr_above_90;
        end
    end

    // sticky flags; a new event in the clearing cycle wins
    always_comb begin
        nxt_int_status = int_status_ff;
        if (wr_stat)
            nxt_int_status = int_status_ff & ~reg_wdata[2:0];
        if (!main_above_90 && !main_warn_ff)
            nxt_int_status[cxm_pkg::IRQ_MAIN_BIT] = 1'b1;
        if (xcvr_regulator_en && !xcvr_above_90 && !xcvr_warn_ff)
            nxt_int_status[cxm_pkg::IRQ_XCVR_BIT] = 1'b1;
        if (wk_bus.wake && lowpower)
            nxt_int_status[cxm_pkg::IRQ_WAKE_BIT] = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            int_status_ff <= 3'h0;
        else
            int_status_ff <= nxt_int_status;
    end

    // open drain: only ever pulls low
    assign interrupt_out_n_o    = 1'b0;
    assign interrupt_out_n_oe_n = !(|int_status_ff);

    // reset pulse stretches past the end of the undervoltage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rst_cnt_ff <= 16'h0000;
        else if (main_uv)
            rst_cnt_ff <= RST_PULSE_CYC;
        else if (rst_cnt_ff != 16'h0000)
            rst_cnt_ff <= rst_cnt_ff - 16'h0001;
    end

    assign system_reset_line_n_o    = 1'b0;
    assign system_reset_line_n_oe_n = (rst_cnt_ff == 16'h0000);

    // transceiver mode
    assign active   = normal_mode && !can_standby_select_ff && xcvr_pin_ok;
    assign lowpower = can_standby_select_ff;
    // anything else, standby or sleep without the standby bit, is off
    assign xcvr_active   = active;
    assign xcvr_lowpower = lowpower;
    assign split_en      = active;

    assign wk_bus.enable  = lowpower;
    assign wk_bus.bus_dom = bus_rx_dominant;

    cxm_wake_filter #(
        .TIMEOUT_CYC (WAKE_TO_CYC)
    ) u_wake (
        .clk   (clk),
        .rst_n (rst_n),
        .wk    (wk_bus)
    );

    // undriven input behaves as the pull-up, recessive
    assign txd_eff = can_transmit_data_oe ? can_transmit_data : 1'b1;

    // dominant timeout; the timer relies on a bit rate of at least 10 kbit/s
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txd_last_ff   <= 1'b1;
            txd_cnt_ff    <= 16'h0000;
            tx_blocked_ff <= 1'b0;
        end else begin
            txd_last_ff <= txd_eff;
            if (txd_eff) begin
                txd_cnt_ff <= 16'h0000;
                if (!txd_last_ff)
                    tx_blocked_ff <= 1'b0;
            end else if (txd_cnt_ff >= TXD_TO_CYC) begin
                tx_blocked_ff <= 1'b1;
            end else begin
                txd_cnt_ff <= txd_cnt_ff + 16'h0001;
            end
        end
    end

    assign bus_tx_dominant = active && !txd_eff && !tx_blocked_ff;

    // receive path idles recessive outside active
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rxd_ff <= 1'b1;
        else
            rxd_ff <= active ? !bus_rx_dominant : 1'b1;
    end
    assign can_receive_data = rxd_ff;

    // register read port, data in the cycle after the strobe
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                cxm_pkg::ADDR_MODE_CTRL:
                    nxt_rdata = {5'h00, power_split_select_ff, operating_mode_field_ff};
                cxm_pkg::ADDR_INT_CTRL:
                    nxt_rdata = {6'h00, reset_threshold_select_ff, can_standby_select_ff};
                cxm_pkg::ADDR_INT_STATUS:
                    nxt_rdata = {5'h00, int_status_ff};
                cxm_pkg::ADDR_WD_STATUS:
                    nxt_rdata = {6'h00, xcvr_supply_ok_flag, main_supply_ok_flag};
                default:
                    nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            reg_rdata_ff <= 8'h00;
        else
            reg_rdata_ff <= nxt_rdata;
    end
    assign reg_rdata = reg_rdata_ff;
endmodule : cxm_can_xcvr_mode_supply_monitor

// File: testbench/cxm_ctrl_model.sv
// behavioural can protocol controller driving the transmit pin
module cxm_ctrl_model (
    input  wire logic clk,
    output logic      tx,
    output logic      tx_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bit_q = 1'b1;
    logic tgl_q = 1'b0;
    initial tx_oe = 1'b0;
    // released pin wanders so a stale level cannot pass for the pull-up
    always @(posedge clk) tgl_q <= ~tgl_q;
    assign tx = tx_oe ? bit_q : tgl_q;
    // one bit for n cycles; 25 to 2500 cycles spans 1 Mbit/s to 10 kbit/s
    task automatic put_bit(input logic b, input int n, input logic drv);
        @(posedge clk);
        bit_q <= b;
        tx_oe <= drv;
        repeat (n - 1) @(posedge clk);
    endtask : put_bit
endmodule : cxm_ctrl_model

// File: testbench/cxm_mon_chk.sv
// concurrent checks on the transceiver mode and supply monitor ports
module cxm_mon_chk #(
    parameter logic [15:0] TXD_TO_CYC    = 16'd200,
    parameter logic [15:0] RST_PULSE_CYC = 16'd20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic main_above_90,
    input wire logic main_above_70,
    input wire logic xcvr_pin_ok,
    input wire logic can_transmit_data,
    input wire logic can_transmit_data_oe,
    input wire logic bus_rx_dominant,
    input wire logic can_receive_data,
    input wire logic bus_tx_dominant,
    input wire logic xcvr_active,
    input wire logic xcvr_lowpower,
    input wire logic split_en,
    input wire logic interrupt_out_n_oe_n,
    input wire logic system_reset_line_n_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lo_ff;
    logic [15:0] ok_ff;
    logic        tx_hi;
    assign tx_hi = can_transmit_data | !can_transmit_data_oe;
    // saturating, so a stuck input cannot wrap the count back to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_ff <= '0;
            ok_ff <= '0;
        end else begin
            lo_ff <= tx_hi ? '0 : lo_ff + 16'(lo_ff != 16'hffff);
            ok_ff <= (main_above_70 && main_above_90) ? ok_ff + 16'(ok_ff != 16'hffff) : '0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    split_follow_a: assert property (split_en == xcvr_active)
        else $error("split output differs from active mode");
    active_cond_a: assert property (xcvr_active |-> xcvr_pin_ok && !xcvr_lowpower)
        else $error("active mode without its conditions");
    rx_path_a: assert property (can_receive_data ==
        ($past(xcvr_active) ? !$past(bus_rx_dominant) : 1'b1))
        else $error("receive data does not follow the bus");
    tx_gate_a: assert property (bus_tx_dominant |-> xcvr_active && !tx_hi)
        else $error("bus driven without active low transmit");
    tx_timeout_a: assert property (lo_ff > TXD_TO_CYC + 16'd3 |-> !bus_tx_dominant)
        else $error("transmitter not cut off after long dominant");
    tx_drive_a: assert property (xcvr_active && !tx_hi && lo_ff >= 16'd1
        && lo_ff < TXD_TO_CYC |-> bus_tx_dominant)
        else $error("dominant transmit not driven onto the bus");
    irq_warn_a: assert property ($fell(main_above_90) |-> ##[1:2] !interrupt_out_n_oe_n)
        else $error("main supply warning not on interrupt line");
    uv_reset_a: assert property (!main_above_70 |=> !system_reset_line_n_oe_n)
        else $error("undervoltage did not pull the reset line");
    pulse_hold_a: assert property ($rose(main_above_70) |-> !system_reset_line_n_oe_n [*8])
        else $error("reset pulse ended too early");
    pulse_end_a: assert property (ok_ff > RST_PULSE_CYC + 16'd3 |-> system_reset_line_n_oe_n)
        else $error("reset line held too long");
endmodule : cxm_mon_chk
bind cxm_can_xcvr_mode_supply_monitor cxm_mon_chk #(
    .TXD_TO_CYC(TXD_TO_CYC), .RST_PULSE_CYC(RST_PULSE_CYC)
) u_chk (
    .clk, .rst_n, .main_above_90, .main_above_70, .xcvr_pin_ok, .can_transmit_data,
    .can_transmit_data_oe, .bus_rx_dominant, .can_receive_data, .bus_tx_dominant,
    .xcvr_active, .xcvr_lowpower, .split_en, .interrupt_out_n_oe_n, .system_reset_line_n_oe_n
);

// File: testbench/testbench.sv
// self-checking bench for the transceiver mode and supply monitor
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] TXD  = 16'd200;
    localparam logic [15:0] RSTP = 16'd20;
    localparam logic [15:0] WKTO = 16'd2000;
    logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic       main_above_90 = 1'b1, main_above_70 = 1'b1, xcvr_above_90 = 1'b1;
    logic       xcvr_pin_ok = 1'b1, bus_rx_dominant = 1'b0, loop = 1'b0, wk_dom = 1'b0;
    logic       can_transmit_data, can_transmit_data_oe, can_receive_data, bus_tx_dominant;
    logic       xcvr_regulator_en, pnp_drive_at_50ma, xcvr_active, xcvr_lowpower, split_en;
    logic       interrupt_out_n_o, interrupt_out_n_oe_n;
    logic       system_reset_line_n_o, system_reset_line_n_oe_n;
    int         failures = 0, n_tests = 0;
    always #20 clk = ~clk;
    // bus echoes our own transmitter, or carries a wake pattern
    always @(posedge clk) bus_rx_dominant <= loop ? bus_tx_dominant : wk_dom;
    cxm_can_xcvr_mode_supply_monitor #(
        .WAKE_TO_CYC(WKTO), .TXD_TO_CYC(TXD), .RST_PULSE_CYC(RSTP)
    ) DUT (
        .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .main_above_90,
        .main_above_70, .xcvr_above_90, .xcvr_pin_ok, .xcvr_regulator_en, .pnp_drive_at_50ma,
        .can_transmit_data, .can_transmit_data_oe, .can_receive_data, .bus_rx_dominant,
        .bus_tx_dominant, .xcvr_active, .xcvr_lowpower, .split_en, .interrupt_out_n_o,
        .interrupt_out_n_oe_n, .system_reset_line_n_o, .system_reset_line_n_oe_n
    );
    cxm_ctrl_model ctl (.clk, .tx(can_transmit_data), .tx_oe(can_transmit_data_oe));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask : rd
    task automatic t_reset;
        rd(8'h00, 8'h00, "mode ctrl");
        rd(8'h01, 8'h00, "int ctrl");
        rd(8'h02, 8'h00, "int status");
        rd(8'h03, 8'h03, "status");
        rd(8'h04, 8'h00, "unmapped");
        chk("irq line idle", 8'(interrupt_out_n_oe_n), 8'h01);
        chk("irq pin level", 8'(interrupt_out_n_o), 8'h00);
        chk("reset line idle", 8'(system_reset_line_n_oe_n), 8'h01);
        chk("reset pin level", 8'(system_reset_line_n_o), 8'h00);
        wr(8'h04, 8'hff);
        rd(8'h00, 8'h00, "unmapped write");
    endtask : t_reset
    task automatic t_modes;
        for (int m = 0; m < 8; m++) begin
            wr(8'h00, {5'h0, m[0] ^ m[2], m[1:0]});
            wr(8'h01, {7'h0, m[2]});
            #1 chk("regulator", 8'(xcvr_regulator_en), 8'(m[1:0] == 2'h3));
            chk("split select", 8'(pnp_drive_at_50ma), 8'(m[0] ^ m[2]));
            chk("active", 8'(xcvr_active), 8'(m[1] & !m[2]));
            chk("lowpower", 8'(xcvr_lowpower), 8'(m[2]));
            chk("split out", 8'(split_en), 8'(m[1] & !m[2]));
        end
        wr(8'h00, 8'h03);
        wr(8'h01, 8'h00);
        @(posedge clk) xcvr_pin_ok <= 1'b0;
        cyc(1);
        chk("active unsupplied", 8'(xcvr_active), 8'h00);
        @(posedge clk) xcvr_pin_ok <= 1'b1;
    endtask : t_modes
    task automatic t_data;
        logic [7:0] b = 8'ha6;
        loop <= 1'b1;
        for (int i = 7; i >= 0; i--) begin
            ctl.put_bit(b[i], 25, 1'b1);
            #1 chk("rx data", 8'(can_receive_data), 8'(b[i]));
        end
        ctl.put_bit(1'b0, TXD + 20, 1'b1);
        #1 chk("tx timeout", 8'(bus_tx_dominant), 8'h00);
        chk("bus released", 8'(can_receive_data), 8'h01);
        ctl.put_bit(1'b1, 4, 1'b1);
        ctl.put_bit(1'b0, 5, 1'b1);
        #1 chk("tx rearmed", 8'(bus_tx_dominant), 8'h01);
        ctl.put_bit(1'b1, 50, 1'b0);
        #1 chk("tx undriven", 8'(bus_tx_dominant), 8'h00);
        loop <= 1'b0;
    endtask : t_data
    task automatic t_supply;
        wr(8'h01, 8'h00);
        @(posedge clk) main_above_90 <= 1'b0;
        cyc(3);
        chk("reset at 90", 8'(system_reset_line_n_oe_n), 8'h00);
        chk("irq line", 8'(interrupt_out_n_oe_n), 8'h00);
        rd(8'h03, 8'h02, "main status low");
        @(posedge clk) main_above_90 <= 1'b1;
        cyc(RSTP + 4);
        chk("reset end", 8'(system_reset_line_n_oe_n), 8'h01);
        rd(8'h02, 8'h01, "main irq");
        wr(8'h02, 8'h01);
        #1 chk("irq cleared", 8'(interrupt_out_n_oe_n), 8'h01);
        wr(8'h01, 8'h02);
        @(posedge clk) main_above_90 <= 1'b0;
        cyc(3);
        chk("no reset at 70", 8'(system_reset_line_n_oe_n), 8'h01);
        rd(8'h03, 8'h03, "status above 70");
        @(posedge clk) main_above_70 <= 1'b0;
        cyc(3);
        chk("reset below 70", 8'(system_reset_line_n_oe_n), 8'h00);
        @(posedge clk) {main_above_70, main_above_90} <= 2'h3;
        wr(8'h02, 8'h01);
        @(posedge clk) xcvr_above_90 <= 1'b0;
        cyc(3);
        rd(8'h03, 8'h01, "xcvr status");
        rd(8'h02, 8'h02, "xcvr irq");
        wr(8'h00, 8'h00);
        rd(8'h03, 8'h03, "xcvr status off");
        @(posedge clk) xcvr_above_90 <= 1'b1;
        wr(8'h02, 8'h07);
        rd(8'h02, 8'h00, "all cleared");
    endtask : t_supply
    task automatic phase(input logic v, input int n);
        @(posedge clk) wk_dom <= v;
        repeat (n - 1) @(posedge clk);
    endtask : phase
    // a standby toggle first, so no half-seen pattern carries over
    task automatic pat(input int d1, input int r2, input logic [7:0] exp);
        wr(8'h01, 8'h00);
        wr(8'h01, 8'h01);
        phase(1'b0, 150);
        phase(1'b1, d1);
        phase(1'b0, 60);
        phase(1'b1, 3);
        phase(1'b0, r2);
        phase(1'b1, d1);
        phase(1'b0, 10);
        rd(8'h02, exp, "wake flag");
    endtask : pat
    task automatic t_wake;
        pat(50, 150, 8'h00);
        pat(150, 2100, 8'h00);
        pat(150, 150, 8'h04);
        chk("wake irq line", 8'(interrupt_out_n_oe_n), 8'h00);
        chk("rx lowpower", 8'(can_receive_data), 8'h01);
        wr(8'h02, 8'h04);
        rd(8'h02, 8'h00, "wake cleared");
    endtask : t_wake
    task automatic give_verdict;
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_modes;
        t_data;
        t_supply;
        t_wake;
        give_verdict;
    end
    // whole run is near 4400 cycles
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        give_verdict;
    end
endmodule : testbench
